// ===== dv/dual_clock_fifo_flag_logic_tb.sv
/* bench for fifo_flag_core: flag latencies, fill, drain, random
   assumes fifo_user_ticks and the bound checker */
`timescale 1ns/1ps
module dual_clock_fifo_flag_logic_tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic first_word_fall_through = 1'b0;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [3:0] wdiv = 4'h1;
   logic [3:0] rdiv = 4'h1;
   logic wt, rt, full, nf, werr, emp, ne, rerr;
   logic [7:0] rdat;
   logic [7:0] e;
   logic [7:0] h;
   logic [3:0] f;
   logic [7:0] q[$];
   int failures = 0;
   int comparisons = 0;
   assign f = {nf, full, ne, emp};
   initial forever #2.5 ref_clk = ~ref_clk;
   fifo_user_ticks i_user (.ref_clk_i(ref_clk), .wr_div_i(wdiv),
      .rd_div_i(rdiv), .write_clock_o(wt), .read_clock_o(rt));
   fifo_flag_core i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
      .first_word_fall_through_i(first_word_fall_through), .write_clock_i(wt),
      .write_enable_i(we), .write_data_in_i(wd), .full_o(full),
      .near_full_flag_o(nf), .write_overflow_error_o(werr),
      .read_clock_i(rt), .read_enable_i(re), .read_data_out_o(rdat),
      .empty_o(emp), .near_empty_flag_o(ne),
      .read_underflow_error_o(rerr));
   // ---------------------------------------------
   // model and tasks
   // ---------------------------------------------
   always @(posedge ref_clk) begin
      if (rst_n && wt && we && !full) q.push_back(wd);
      if (rst_n && rt && re && !emp) begin
         e = q.pop_front();
         if (!first_word_fall_through) #1 chk("read data", e, rdat);
      end
   end
   always @(negedge ref_clk) begin
      if (rst_n && first_word_fall_through && !emp) begin
         h = (q.size() > 0) ? q[0] : 8'hXX;
         chk("head data", h, rdat);
      end
   end
   task automatic chk(string n, logic [7:0] x, logic [7:0] g);
      comparisons++;
      if (g !== x) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic wr(logic [7:0] d);
      @(negedge ref_clk);
      we = 1'b1;
      wd = d;
      do @(posedge ref_clk); while (!wt);
   endtask : wr
   task automatic rd();
      @(negedge ref_clk);
      re = 1'b1;
      do @(posedge ref_clk); while (!rt);
   endtask : rd
   task automatic idle();
      @(negedge ref_clk);
      we = 1'b0;
      re = 1'b0;
   endtask : idle
   task automatic rst(logic m);
      @(negedge ref_clk);
      rst_n = 1'b0;
      first_word_fall_through = m;
      q.delete();
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      chk("reset", 8'h03, {2'h0, werr, rerr, f});
   endtask : rst
   task automatic lat(int s, int x);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n += (s < 2) ? rt : wt;
         #1;
      end while (f[s]);
      chk("latency", x[7:0], n[7:0]);
   endtask : lat
   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      #100000;
      failures++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'hFF27));
      rst(1'b0);
      wr(8'hA5);
      idle();
      lat(0, 3);
      chk("std head", 8'h00, rdat);
      rst(1'b1);
      wr(8'h3C);
      idle();
      lat(0, 4);
      chk("first_word_fall_through head", 8'h3C, rdat);
      for (int i = 0; i < 3; i++) wr(8'(i));
      idle();
      lat(1, 3);
      $display("test latency done");
      rst(1'b0);
      for (int i = 0; i < 16; i++) begin
         wr(8'(i));
         #1;
         chk("near full", 8'(i >= 12), 8'(nf));
         chk("full", 8'(i == 15), 8'(full));
      end
      wr(8'hEE);
      #1;
      chk("write error", 8'h01, 8'(werr));
      idle();
      @(posedge ref_clk);
      #1;
      chk("write error off", 8'h00, 8'(werr));
      rd();
      idle();
      lat(2, 3);
      for (int i = 0; i < 3; i++) rd();
      idle();
      lat(3, 3);
      for (int i = 11; i >= 0; i--) begin
         rd();
         #1;
         chk("near empty", 8'(i <= 3), 8'(ne));
         chk("empty", 8'(i == 0), 8'(emp));
      end
      rd();
      #1;
      chk("read error", 8'h01, 8'(rerr));
      chk("held data", 8'h0F, rdat);
      idle();
      @(posedge ref_clk);
      #1;
      chk("read error off", 8'h00, 8'(rerr));
      $display("test fill and drain done");
      wdiv = 4'h2;
      rdiv = 4'h3;
      for (int m = 0; m < 2; m++) begin
         rst(1'(m));
         repeat (3000) begin
            @(negedge ref_clk);
            we = 1'($urandom);
            re = 1'($urandom);
            wd = 8'($urandom);
         end
         @(negedge ref_clk);
         we = 1'b0;
         re = 1'b1;
         repeat (200) @(negedge ref_clk);
         chk("words left", 8'h00, 8'(q.size()));
         re = 1'b0;
      end
      $display("test random done");
      report_and_stop();
   end
endmodule : dual_clock_fifo_flag_logic_tb

// ===== dv/fifo_flag_core_assertions.sv
/* flag timing checker for fifo_flag_core
   bound to every fifo_flag_core, sees only its ports */
`timescale 1ns/1ps
module fifo_flag_core_chk #(parameter int DATA_W = 8) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic first_word_fall_through_i,
   input wire logic write_clock_i,
   input wire logic write_enable_i,
   input wire logic full_o,
   input wire logic near_full_flag_o,
   input wire logic write_overflow_error_o,
   input wire logic read_clock_i,
   input wire logic read_enable_i,
   input wire logic [DATA_W-1:0] read_data_out_o,
   input wire logic empty_o,
   input wire logic near_empty_flag_o,
   input wire logic read_underflow_error_o
);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_wr_err_eval:
   assert property (write_clock_i |=> write_overflow_error_o ==
      $past(write_enable_i && full_o)) else $error("wr err");
   a_wr_err_hold:
   assert property (!write_clock_i |=> $stable(write_overflow_error_o))
      else $error("wr err moved");
   a_rd_err_eval:
   assert property (read_clock_i |=> read_underflow_error_o ==
      $past(read_enable_i && empty_o)) else $error("rd err");
   a_rd_data_hold:
   assert property (!first_word_fall_through_i && read_clock_i &&
      read_enable_i && empty_o |=> $stable(read_data_out_o))
      else $error("data moved");
   a_full_rise_cause:
   assert property ($rose(full_o) |-> $past(write_clock_i &&
      write_enable_i)) else $error("full rise");
   a_nfull_rise_cause:
   assert property ($rose(near_full_flag_o) |-> $past(write_clock_i &&
      write_enable_i)) else $error("near full rise");
   a_empty_rise_cause:
   assert property ($rose(empty_o) |-> $past(read_clock_i &&
      read_enable_i)) else $error("empty rise");
   a_nempty_rise_cause:
   assert property ($rose(near_empty_flag_o) |-> $past(read_clock_i &&
      read_enable_i)) else $error("near empty rise");
   a_full_drop_tick:
   assert property ($fell(full_o) |-> $past(write_clock_i))
      else $error("full drop");
   a_empty_drop_tick:
   assert property ($fell(empty_o) |-> $past(read_clock_i))
      else $error("empty drop");
endmodule : fifo_flag_core_chk
bind fifo_flag_core fifo_flag_core_chk #(.DATA_W(DATA_W)) i_chk (.*);

// ===== dv/fifo_user_ticks.sv
/* user side tick maker: write and read rates as tick enables
   divisors come from the bench, ticks change on the falling edge */
`timescale 1ns/1ps
module fifo_user_ticks (
   input wire logic ref_clk_i,
   input wire logic [3:0] wr_div_i,
   input wire logic [3:0] rd_div_i,
   output logic write_clock_o = 1'b0,
   output logic read_clock_o = 1'b0
);
   logic [3:0] wc = 4'h0;
   logic [3:0] rc = 4'h0;
   always @(negedge ref_clk_i) begin
      wc <= (wc + 4'h1 >= wr_div_i) ? 4'h0 : wc + 4'h1;
      rc <= (rc + 4'h1 >= rd_div_i) ? 4'h0 : rc + 4'h1;
      write_clock_o <= (wc == 4'h0);
      read_clock_o <= (rc == 4'h0);
   end
endmodule : fifo_user_ticks

// ===== verilog/fifo_flag_core.sv
/*
 FIFO with full, near-full, empty, near-empty and error flags, standard or
 first-word-fall-through read. Write and read rates are tick enables on
 ref_clk_i; pointers cross between the two sides gray-coded.
 Assumes the mode input is static while the FIFO holds data and that
 reset is held low for three ticks of each side.
*/
// How it works
// - near-empty drops three read ticks after the write lifting occupancy
// - fall-through shows the head word with no read; standard waits a read
// - near-empty drop may come one read tick late when ticks coincide
// - write into near-full FIFO raises near-full at that write tick
// - write filling last slot raises full at that write tick
// - full stays up across a read then write while full
// - write while full is dropped and raises write overflow error
// - write error recomputed each write tick: enable and full
// - read from full FIFO gives oldest word; full drops three ticks on
// - near-full drops three write ticks after the read crossing below
// - near-full and full drop may take one more write tick
// - fall-through data appears on the same read tick as the earliest standard data
// - read from near-empty FIFO raises near-empty at that read tick
// - read of last word shows it and raises empty at that tick
// - empty stays up across a write then read while empty
// - read while empty raises read error; data output holds unless the fall-through head word loads on that tick
// - read error recomputed each read tick: enable and empty
// - reset sets empty and near-empty, clears full and near-full
// - empty drops three read ticks after write, four in fall-through
// - two offset parameters set the near thresholds on stored words
`timescale 1ns/1ps
module fifo_flag_core #(
   parameter int DATA_W = fifo_flag_pkg::DATA_W_DEF,
   parameter int ADDR_W = fifo_flag_pkg::ADDR_W_DEF,
   parameter int NEAR_EMPTY_OFFSET = fifo_flag_pkg::NEAR_EMPTY_OFFSET_DEF,
   parameter int NEAR_FULL_OFFSET = fifo_flag_pkg::NEAR_FULL_OFFSET_DEF
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic first_word_fall_through_i,
   input wire logic write_clock_i,
   input wire logic write_enable_i,
   input wire logic [DATA_W-1:0] write_data_in_i,
   output logic full_o,
   output logic near_full_flag_o,
   output logic write_overflow_error_o,
   input wire logic read_clock_i,
   input wire logic read_enable_i,
   output logic [DATA_W-1:0] read_data_out_o,
   output logic empty_o,
   output logic near_empty_flag_o,
   output logic read_underflow_error_o
);

   localparam int PW = ADDR_W + 1;
   localparam int DEPTH = 1 << ADDR_W;
   localparam logic [PW-1:0] DEPTH_CNT = PW'(DEPTH);
   localparam logic [PW-1:0] NE_LEVEL = PW'(NEAR_EMPTY_OFFSET);
   localparam logic [PW-1:0] NF_LEVEL = PW'(DEPTH - NEAR_FULL_OFFSET);

   // ------------------------------------------------------------
   // gray helpers
   // ------------------------------------------------------------
   function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
      to_gray = b ^ (b >> 1);
   endfunction : to_gray

   function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = '0;
      for (int i = PW - 1; i >= 0; i--) begin
         if (i == PW - 1) begin
            b[i] = g[i];
         end else begin
            b[i] = b[i+1] ^ g[i];
         end
      end
      from_gray = b;
   endfunction : from_gray

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];

   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] wr_gray;
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] rd_gray;
   logic [PW-1:0] rd_gray_sync;
   logic [PW-1:0] wr_gray_sync;
   logic [PW-1:0] rd_bin_sync;
   logic [PW-1:0] wr_bin_sync;

   // ------------------------------------------------------------
   // pointer crossings
   // ------------------------------------------------------------
   gray_ptr_sync #(
      .W(PW)
   ) u_rd_to_wr (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(write_clock_i),
      .gray_i(rd_gray),
      .gray_o(rd_gray_sync)
   );

   gray_ptr_sync #(
      .W(PW)
   ) u_wr_to_rd (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(read_clock_i),
      .gray_i(wr_gray),
      .gray_o(wr_gray_sync)
   );

   assign rd_bin_sync = from_gray(rd_gray_sync);
   assign wr_bin_sync = from_gray(wr_gray_sync);

   // ------------------------------------------------------------
   // write side
   // ------------------------------------------------------------
   logic wr_accept;
   logic [PW-1:0] next_wr_ptr;
   logic [PW-1:0] wr_occupancy;

   assign wr_accept = write_enable_i && !full_o;
   assign next_wr_ptr = wr_ptr + PW'(wr_accept);
   assign wr_occupancy = next_wr_ptr - rd_bin_sync;

   always_ff @(posedge ref_clk_i) begin
      if (write_clock_i && wr_accept) begin
         mem[wr_ptr[ADDR_W-1:0]] <= write_data_in_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         wr_gray <= '0;
      end else if (write_clock_i) begin
         wr_ptr <= next_wr_ptr;
         wr_gray <= to_gray(next_wr_ptr);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         full_o <= fifo_flag_pkg::FULL_RST;
         near_full_flag_o <= fifo_flag_pkg::NEAR_FULL_RST;
      end else if (write_clock_i) begin
         full_o <= (wr_occupancy == DEPTH_CNT);
         near_full_flag_o <= (wr_occupancy >= NF_LEVEL);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_overflow_error_o <= fifo_flag_pkg::ERR_RST;
      end else if (write_clock_i) begin
         write_overflow_error_o <= write_enable_i && full_o;
      end
   end

   // ------------------------------------------------------------
   // read side
   // ------------------------------------------------------------
   logic head_valid;
   logic mem_avail;
   logic std_pop;
   logic ft_consume;
   logic ft_load;
   logic pop;
   logic next_head_valid;
   logic [PW-1:0] next_rd_ptr;
   logic [PW-1:0] rd_occupancy;
   logic next_empty;

   assign std_pop = read_enable_i && !empty_o;
   assign ft_consume = read_enable_i && head_valid;
   assign ft_load = mem_avail && (!head_valid || ft_consume);
   assign pop = first_word_fall_through_i ? ft_load : std_pop;
   assign next_rd_ptr = rd_ptr + PW'(pop);

   always_comb begin
      next_head_valid = head_valid;
      if (ft_load) begin
         next_head_valid = 1'b1;
      end else if (ft_consume) begin
         next_head_valid = 1'b0;
      end
   end

   always_comb begin
      rd_occupancy = wr_bin_sync - next_rd_ptr;
      if (first_word_fall_through_i) begin
         rd_occupancy = rd_occupancy + PW'(next_head_valid);
         next_empty = !next_head_valid;
      end else begin
         next_empty = (rd_occupancy == '0);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_ptr <= '0;
         rd_gray <= '0;
      end else if (read_clock_i) begin
         rd_ptr <= next_rd_ptr;
         rd_gray <= to_gray(next_rd_ptr);
      end
   end

   // extra stage gives the fall-through path its fourth tick
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_avail <= 1'b0;
         head_valid <= 1'b0;
      end else if (read_clock_i) begin
         mem_avail <= first_word_fall_through_i &&
            (wr_bin_sync != next_rd_ptr);
         head_valid <= first_word_fall_through_i && next_head_valid;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_data_out_o <= '0;
      end else if (read_clock_i && pop) begin
         read_data_out_o <= mem[rd_ptr[ADDR_W-1:0]];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         empty_o <= fifo_flag_pkg::EMPTY_RST;
         near_empty_flag_o <= fifo_flag_pkg::NEAR_EMPTY_RST;
      end else if (read_clock_i) begin
         empty_o <= next_empty;
         near_empty_flag_o <= (rd_occupancy <= NE_LEVEL);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_underflow_error_o <= fifo_flag_pkg::ERR_RST;
      end else if (read_clock_i) begin
         read_underflow_error_o <= read_enable_i && empty_o;
      end
   end

endmodule : fifo_flag_core

// ===== verilog/fifo_flag_pkg.sv
/*
 Shared constants for the dual-rate FIFO flag logic: default geometry,
 default flag thresholds and the reset levels of the status flags.
 Assumes one system clock; read and write rates arrive as tick enables.
*/
package fifo_flag_pkg;

   // ------------------------------------------------------------
   // geometry defaults
   // ------------------------------------------------------------
   localparam int DATA_W_DEF = 8;
   localparam int ADDR_W_DEF = 4;

   // ------------------------------------------------------------
   // threshold defaults, in stored words
   // ------------------------------------------------------------
   localparam int NEAR_EMPTY_OFFSET_DEF = 3;
   localparam int NEAR_FULL_OFFSET_DEF = 3;

   // ------------------------------------------------------------
   // flag levels at reset
   // ------------------------------------------------------------
   localparam logic EMPTY_RST = 1'b1;
   localparam logic NEAR_EMPTY_RST = 1'b1;
   localparam logic FULL_RST = 1'b0;
   localparam logic NEAR_FULL_RST = 1'b0;
   localparam logic ERR_RST = 1'b0;

endpackage : fifo_flag_pkg

// ===== verilog/gray_ptr_sync.sv
/*
 Two-stage synchroniser for a gray-coded pointer.
 Assumes the destination side advances only on its own tick enable.
*/
`timescale 1ns/1ps
module gray_ptr_sync #(
   parameter int W = 5
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic [W-1:0] gray_i,
   output logic [W-1:0] gray_o
);

   logic [W-1:0] stage_one;

   // ------------------------------------------------------------
   // two flops, first one read only by the second
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage_one <= '0;
         gray_o <= '0;
      end else if (tick_i) begin
         stage_one <= gray_i;
         gray_o <= stage_one;
      end
   end

endmodule : gray_ptr_sync
